//--- core/timer_pkg.sv
// Constants for the dual timer/counter block: register map, field positions, timing.
// Assumes an 8-bit register bus clocked by mclk.
package timer_pkg;
	localparam logic [11:0] addr_timer01_control   = 12'h410;
	localparam logic [11:0] addr_timer01_ext_stat  = 12'h411;
	localparam logic [11:0] addr_timer2_control    = 12'h418;
	localparam logic [11:0] addr_timer2_mode       = 12'h419;
	localparam logic [11:0] addr_timer0_low_count  = 12'h450;
	localparam logic [11:0] addr_timer0_high_count = 12'h451;
	localparam logic [11:0] addr_timer1_low_count  = 12'h452;
	localparam logic [11:0] addr_timer1_high_count = 12'h453;
	localparam logic [11:0] addr_timer01_mode      = 12'h45c;
	localparam logic [11:0] addr_reload0_low       = 12'h454;
	localparam logic [11:0] addr_reload0_high      = 12'h455;
	localparam logic [11:0] addr_reload1_low       = 12'h456;
	localparam logic [11:0] addr_reload1_high      = 12'h457;
	localparam logic [11:0] addr_sys_config        = 12'h440;

	localparam logic [7:0] reset_byte = 8'h00;

	// Control, extended status and timer 2 mode register bit positions
	localparam int tf1_bit = 7;
	localparam int tr1_bit = 6;
	localparam int tf0_bit = 5;
	localparam int tr0_bit = 4;
	localparam int ie1_bit = 3;
	localparam int it1_bit = 2;
	localparam int ie0_bit = 1;
	localparam int it0_bit = 0;
	localparam int tf2_bit = 7;
	localparam int timer2_external_flag_bit = 6;
	localparam int uart0_rx_baud_select_bit = 5;
	localparam int uart0_tx_baud_select_bit = 4;
	localparam int timer2_external_enable_bit = 3;
	localparam int uart1_rx_baud_select_bit = 5;
	localparam int uart1_tx_baud_select_bit = 4;
	localparam int timer2_clockout_enable_bit = 1;
	localparam int timer1_toggle_out_enable_bit = 2;
	localparam int timer0_toggle_out_enable_bit = 0;

	// Mode register: timer 1 in high nibble, timer 0 in low nibble
	localparam int gate_ofs = 3;
	localparam int ct_ofs = 2;
	localparam int nib1 = 4;

	typedef enum logic [1:0] {
		mode_reload16 = 2'h0,
		mode_plain16  = 2'h1,
		mode_reload8  = 2'h2,
		mode_split    = 2'h3
	} timer_mode_t;

	typedef enum logic [1:0] {
		pre_div4  = 2'h0,
		pre_div16 = 2'h1,
		pre_div64 = 2'h2
	} prescale_t;

	localparam logic [5:0] div4_last  = 6'h03;
	localparam logic [5:0] div16_last = 6'h0f;
	localparam logic [5:0] div64_last = 6'h3f;
	// Oscillator is mclk; pins sampled every two oscillator cycles
	localparam int osc_period_ns = 10;
	localparam int sample_ns = 20;
	localparam logic sample_last = 1'((sample_ns + osc_period_ns - 1) / osc_period_ns - 1);
endpackage

//--- core/dual_timer_modes.sv
// Timer 0 and timer 1 with modes 0..3, their control register, ext-interrupt flags,
// and the overflow/external flags of the third timer's control register.
// Assumes: pins are asynchronous; interrupt acknowledges are one-cycle pulses on mclk.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_modes (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        count0_pin,
	input  wire logic        count1_pin,
	input  wire logic        ext_interrupt0_pin,
	input  wire logic        ext_interrupt1_pin,
	input  wire logic        timer2_external_pin,
	input  wire logic        timer2_overflow_event,
	input  wire logic        timer2_trigger_event,
	input  wire logic        ack_timer0,
	input  wire logic        ack_timer1,
	input  wire logic        ack_ext0,
	input  wire logic        ack_ext1,
	output logic             timer0_overflow_flag,
	output logic             timer1_overflow_flag,
	output logic             ext_ext_interrupt0_pin_edge_flag,
	output logic             ext_int1_edge_flag,
	output logic             ext_ext_interrupt0_pin_request,
	output logic             ext_int1_request,
	output logic             timer2_overflow_flag,
	output logic             timer2_external_flag
);
	logic [7:0] timer01_mode_register;
	logic [7:0] timer01_extended_status;
	logic [7:0] timer2_mode;
	logic [1:0] prescale;
	logic       timer0_run;
	logic       timer1_run;
	logic       ext_ext_interrupt0_pin_type;
	logic       ext_int1_type;
	logic [7:0] timer2_low_bits;
	logic [7:0] timer0_low_count;
	logic [7:0] timer0_high_count;
	logic [7:0] timer1_low_count;
	logic [7:0] timer1_high_count;
	logic [7:0] reload0_low_byte;
	logic [7:0] reload0_high_byte;
	logic [7:0] reload1_low_byte;
	logic [7:0] reload1_high_byte;

	// Pin synchronisers
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic [4:0] pin_prev;
	logic       sample_cnt;
	logic       sample_tick;

	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_meta <= 5'h1f;
			pin_sync <= 5'h1f;
		end else if (clk_en) begin
			pin_meta <= {timer2_external_pin, ext_interrupt1_pin, ext_interrupt0_pin,
				count1_pin, count0_pin};
			pin_sync <= pin_meta;
		end
	end

	// Pins looked at once every two oscillator cycles
	always_ff @(posedge mclk) begin
		if (reset) begin
			sample_cnt <= 1'b0;
			pin_prev <= 5'h1f;
		end else if (clk_en) begin
			sample_cnt <= (sample_cnt == timer_pkg::sample_last) ? 1'b0 : sample_cnt + 1'b1;
			if (sample_tick)
				pin_prev <= pin_sync;
		end
	end
	assign sample_tick = (sample_cnt == timer_pkg::sample_last);

	logic [4:0] pin_fall;
	assign pin_fall = sample_tick ? (pin_prev & ~pin_sync) : 5'h00;

	// Shared base clock
	logic [5:0] pre_cnt;
	logic [5:0] pre_last;
	logic       base_tick;
	always_comb begin
		case (prescale)
			timer_pkg::pre_div16: pre_last = timer_pkg::div16_last;
			timer_pkg::pre_div64: pre_last = timer_pkg::div64_last;
			default:              pre_last = timer_pkg::div4_last;
		endcase
	end
	assign base_tick = (pre_cnt >= pre_last);
	always_ff @(posedge mclk) begin
		if (reset)
			pre_cnt <= 6'h00;
		else if (clk_en)
			pre_cnt <= base_tick ? 6'h00 : pre_cnt + 6'h01;
	end

	// Per-timer control decode
	logic [1:0] mode0;
	logic [1:0] mode1;
	logic       tick0;
	logic       tick1;
	logic       en0;
	logic       en1;
	logic       split0;
	always_comb begin
		mode0 = timer01_mode_register[1:0];
		mode1 = timer01_mode_register[timer_pkg::nib1 +: 2];
		split0 = (mode0 == timer_pkg::mode_split);
		tick0 = timer01_mode_register[timer_pkg::ct_ofs] ? pin_fall[0] : base_tick;
		tick1 = timer01_mode_register[timer_pkg::nib1 + timer_pkg::ct_ofs] ?
			pin_fall[1] : base_tick;
		en0 = timer0_run && (!timer01_mode_register[timer_pkg::gate_ofs] || pin_sync[2]);
		en1 = timer1_run && (mode1 != timer_pkg::mode_split) &&
			(!timer01_mode_register[timer_pkg::nib1 + timer_pkg::gate_ofs] ||
			pin_sync[3]);
	end

	// Register write strobes
	logic wr_ctl;
	logic wr_t0l;
	logic wr_t0h;
	logic wr_t1l;
	logic wr_t1h;
	assign wr_ctl = clk_en && reg_wr && (reg_addr == timer_pkg::addr_timer01_control);
	assign wr_t0l = clk_en && reg_wr && (reg_addr == timer_pkg::addr_timer0_low_count);
	assign wr_t0h = clk_en && reg_wr && (reg_addr == timer_pkg::addr_timer0_high_count);
	assign wr_t1l = clk_en && reg_wr && (reg_addr == timer_pkg::addr_timer1_low_count);
	assign wr_t1h = clk_en && reg_wr && (reg_addr == timer_pkg::addr_timer1_high_count);

	// Timer 0 counting
	logic ovf0;
	logic ovf0h;
	// Overflow pulses also freeze while clk_en is low
	always_ff @(posedge mclk) begin
		if (reset) begin
			ovf0 <= 1'b0;
			ovf0h <= 1'b0;
			timer0_low_count <= timer_pkg::reset_byte;
			timer0_high_count <= timer_pkg::reset_byte;
		end else if (clk_en) begin
			ovf0 <= 1'b0;
			ovf0h <= 1'b0;
			if (en0 && tick0) begin
				case (mode0)
					timer_pkg::mode_reload16: begin
						if ({timer0_high_count, timer0_low_count} == 16'hffff) begin
							timer0_low_count <= reload0_low_byte;
							timer0_high_count <= reload0_high_byte;
							ovf0 <= 1'b1;
						end else
							{timer0_high_count, timer0_low_count} <=
								{timer0_high_count, timer0_low_count} + 16'h0001;
					end
					timer_pkg::mode_plain16: begin
						{timer0_high_count, timer0_low_count} <=
							{timer0_high_count, timer0_low_count} + 16'h0001;
						ovf0 <= ({timer0_high_count, timer0_low_count} == 16'hffff);
					end
					timer_pkg::mode_reload8: begin
						if (timer0_low_count == 8'hff) begin
							timer0_low_count <= reload0_low_byte;
							ovf0 <= 1'b1;
						end else
							timer0_low_count <= timer0_low_count + 8'h01;
					end
					default: begin
						timer0_low_count <= timer0_low_count + 8'h01;
						ovf0 <= (timer0_low_count == 8'hff);
					end
				endcase
			end
			if (split0 && timer1_run && base_tick) begin
				timer0_high_count <= timer0_high_count + 8'h01;
				ovf0h <= (timer0_high_count == 8'hff);
			end
			if (wr_t0l)
				timer0_low_count <= reg_wdata;
			if (wr_t0h)
				timer0_high_count <= reg_wdata;
		end
	end

	// Timer 1 counting
	logic ovf1;
	always_ff @(posedge mclk) begin
		if (reset) begin
			ovf1 <= 1'b0;
			timer1_low_count <= timer_pkg::reset_byte;
			timer1_high_count <= timer_pkg::reset_byte;
		end else if (clk_en) begin
			ovf1 <= 1'b0;
			if (en1 && tick1) begin
				case (mode1)
					timer_pkg::mode_reload16: begin
						if ({timer1_high_count, timer1_low_count} == 16'hffff) begin
							timer1_low_count <= reload1_low_byte;
							timer1_high_count <= reload1_high_byte;
							ovf1 <= 1'b1;
						end else
							{timer1_high_count, timer1_low_count} <=
								{timer1_high_count, timer1_low_count} + 16'h0001;
					end
					timer_pkg::mode_reload8: begin
						if (timer1_low_count == 8'hff) begin
							timer1_low_count <= reload1_low_byte;
							ovf1 <= 1'b1;
						end else
							timer1_low_count <= timer1_low_count + 8'h01;
					end
					default: begin
						{timer1_high_count, timer1_low_count} <=
							{timer1_high_count, timer1_low_count} + 16'h0001;
						ovf1 <= ({timer1_high_count, timer1_low_count} == 16'hffff);
					end
				endcase
			end
			if (wr_t1l)
				timer1_low_count <= reg_wdata;
			if (wr_t1h)
				timer1_high_count <= reg_wdata;
		end
	end

	// Timer 1 overflow in split mode is unused; timer 0 high byte overflow sets the flag
	logic set_tf1;
	logic set_tf0;
	assign set_tf1 = (split0 ? ovf0h : ovf1) &&
		!timer01_extended_status[timer_pkg::timer1_toggle_out_enable_bit];
	assign set_tf0 = ovf0 && !timer01_extended_status[timer_pkg::timer0_toggle_out_enable_bit];

	// External interrupt edge flags
	logic set_ie0;
	logic set_ie1;
	assign set_ie0 = ext_ext_interrupt0_pin_type && pin_fall[2];
	assign set_ie1 = ext_int1_type && pin_fall[3];

	// Control register; hardware set wins over any clear in the same cycle
	always_ff @(posedge mclk) begin
		if (reset) begin
			timer1_overflow_flag <= 1'b0;
			timer0_overflow_flag <= 1'b0;
			ext_int1_edge_flag <= 1'b0;
			ext_ext_interrupt0_pin_edge_flag <= 1'b0;
			timer1_run <= 1'b0;
			timer0_run <= 1'b0;
			ext_int1_type <= 1'b0;
			ext_ext_interrupt0_pin_type <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctl) begin
				timer1_run <= reg_wdata[timer_pkg::tr1_bit];
				timer0_run <= reg_wdata[timer_pkg::tr0_bit];
				ext_int1_type <= reg_wdata[timer_pkg::it1_bit];
				ext_ext_interrupt0_pin_type <= reg_wdata[timer_pkg::it0_bit];
			end
			if (set_tf1)
				timer1_overflow_flag <= 1'b1;
			else if (ack_timer1)
				timer1_overflow_flag <= 1'b0;
			else if (wr_ctl)
				timer1_overflow_flag <= reg_wdata[timer_pkg::tf1_bit];
			if (set_tf0)
				timer0_overflow_flag <= 1'b1;
			else if (ack_timer0)
				timer0_overflow_flag <= 1'b0;
			else if (wr_ctl)
				timer0_overflow_flag <= reg_wdata[timer_pkg::tf0_bit];
			if (set_ie1)
				ext_int1_edge_flag <= 1'b1;
			else if (ack_ext1 || !ext_int1_type)
				ext_int1_edge_flag <= 1'b0;
			else if (wr_ctl)
				ext_int1_edge_flag <= reg_wdata[timer_pkg::ie1_bit];
			if (set_ie0)
				ext_ext_interrupt0_pin_edge_flag <= 1'b1;
			else if (ack_ext0 || !ext_ext_interrupt0_pin_type)
				ext_ext_interrupt0_pin_edge_flag <= 1'b0;
			else if (wr_ctl)
				ext_ext_interrupt0_pin_edge_flag <= reg_wdata[timer_pkg::ie0_bit];
		end
	end

	// Interrupt requests: edge flag or low level
	always_ff @(posedge mclk) begin
		if (reset) begin
			ext_ext_interrupt0_pin_request <= 1'b0;
			ext_int1_request <= 1'b0;
		end else if (clk_en) begin
			ext_ext_interrupt0_pin_request <= ext_ext_interrupt0_pin_type ? ext_ext_interrupt0_pin_edge_flag : !pin_sync[2];
			ext_int1_request <= ext_int1_type ? ext_int1_edge_flag : !pin_sync[3];
		end
	end

	// Third timer control flags
	logic t2_blocked;
	logic wr_t2c;
	assign wr_t2c = clk_en && reg_wr && (reg_addr == timer_pkg::addr_timer2_control);
	assign t2_blocked = timer2_low_bits[timer_pkg::uart0_rx_baud_select_bit] ||
		timer2_low_bits[timer_pkg::uart0_tx_baud_select_bit] || timer2_mode[timer_pkg::uart1_rx_baud_select_bit] ||
		timer2_mode[timer_pkg::uart1_tx_baud_select_bit] || timer2_mode[timer_pkg::timer2_clockout_enable_bit];
	always_ff @(posedge mclk) begin
		if (reset) begin
			timer2_overflow_flag <= 1'b0;
			timer2_external_flag <= 1'b0;
			timer2_low_bits <= timer_pkg::reset_byte;
		end else if (clk_en) begin
			if (wr_t2c)
				timer2_low_bits <= {2'b00, reg_wdata[5:0]};
			if (timer2_overflow_event && !t2_blocked)
				timer2_overflow_flag <= 1'b1;
			else if (wr_t2c)
				timer2_overflow_flag <= reg_wdata[timer_pkg::tf2_bit];
			if (timer2_trigger_event && timer2_low_bits[timer_pkg::timer2_external_enable_bit] && pin_fall[4])
				timer2_external_flag <= 1'b1;
			else if (wr_t2c)
				timer2_external_flag <= reg_wdata[timer_pkg::timer2_external_flag_bit];
		end
	end

	// Configuration and reload registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			timer01_mode_register <= timer_pkg::reset_byte;
			timer01_extended_status <= timer_pkg::reset_byte;
			timer2_mode <= timer_pkg::reset_byte;
			prescale <= timer_pkg::pre_div4;
			reload0_low_byte <= timer_pkg::reset_byte;
			reload0_high_byte <= timer_pkg::reset_byte;
			reload1_low_byte <= timer_pkg::reset_byte;
			reload1_high_byte <= timer_pkg::reset_byte;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == timer_pkg::addr_timer01_mode)
				timer01_mode_register <= reg_wdata;
			else if (reg_addr == timer_pkg::addr_timer01_ext_stat)
				timer01_extended_status <= reg_wdata & 8'h05;
			else if (reg_addr == timer_pkg::addr_timer2_mode)
				timer2_mode <= reg_wdata & 8'h33;
			else if (reg_addr == timer_pkg::addr_sys_config)
				prescale <= reg_wdata[1:0];
			else if (reg_addr == timer_pkg::addr_reload0_low)
				reload0_low_byte <= reg_wdata;
			else if (reg_addr == timer_pkg::addr_reload0_high)
				reload0_high_byte <= reg_wdata;
			else if (reg_addr == timer_pkg::addr_reload1_low)
				reload1_low_byte <= reg_wdata;
			else if (reg_addr == timer_pkg::addr_reload1_high)
				reload1_high_byte <= reg_wdata;
		end
	end

	// Read port, registered
	logic [7:0] next_rdata;
	always_comb begin
		if (reg_addr == timer_pkg::addr_timer01_control)
			next_rdata = {timer1_overflow_flag, timer1_run, timer0_overflow_flag, timer0_run,
				ext_int1_edge_flag, ext_int1_type, ext_ext_interrupt0_pin_edge_flag, ext_ext_interrupt0_pin_type};
		else if (reg_addr == timer_pkg::addr_timer2_control)
			next_rdata = {timer2_overflow_flag, timer2_external_flag, timer2_low_bits[5:0]};
		else if (reg_addr == timer_pkg::addr_timer01_ext_stat)
			next_rdata = timer01_extended_status;
		else if (reg_addr == timer_pkg::addr_timer2_mode)
			next_rdata = timer2_mode;
		else if (reg_addr == timer_pkg::addr_timer01_mode)
			next_rdata = timer01_mode_register;
		else if (reg_addr == timer_pkg::addr_sys_config)
			next_rdata = {6'h00, prescale};
		else if (reg_addr == timer_pkg::addr_timer0_low_count)
			next_rdata = timer0_low_count;
		else if (reg_addr == timer_pkg::addr_timer0_high_count)
			next_rdata = timer0_high_count;
		else if (reg_addr == timer_pkg::addr_timer1_low_count)
			next_rdata = timer1_low_count;
		else if (reg_addr == timer_pkg::addr_timer1_high_count)
			next_rdata = timer1_high_count;
		else if (reg_addr == timer_pkg::addr_reload0_low)
			next_rdata = reload0_low_byte;
		else if (reg_addr == timer_pkg::addr_reload0_high)
			next_rdata = reload0_high_byte;
		else if (reg_addr == timer_pkg::addr_reload1_low)
			next_rdata = reload1_low_byte;
		else if (reg_addr == timer_pkg::addr_reload1_high)
			next_rdata = reload1_high_byte;
		else
			next_rdata = 8'h00;
	end
	always_ff @(posedge mclk) begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (clk_en && reg_rd)
			reg_rdata <= next_rdata;
	end
endmodule // dual_timer_modes
`default_nettype wire

//--- test/dual_timer_modes_properties.sv
// Checker for the dual timer block, watching only its ports.
// Assumes the single mclk domain; bound to every dual_timer_modes instance.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_modes_properties (
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        clk_en,
	input wire logic [11:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        ext_interrupt0_pin,
	input wire logic        timer2_overflow_event,
	input wire logic        timer0_overflow_flag,
	input wire logic        ext_ext_interrupt0_pin_edge_flag,
	input wire logic        ext_ext_interrupt0_pin_request,
	input wire logic        timer2_overflow_flag,
	input wire logic        timer2_external_flag
);
	logic [7:0] c0, c2, m2;
	logic [7:0] rl [4];
	logic       wr, rd, blk, wr2;
	assign wr = clk_en && reg_wr;
	assign rd = clk_en && reg_rd && !reg_wr;
	assign wr2 = wr && reg_addr == 12'h418;
	assign blk = c2[5] | c2[4] | m2[5] | m2[4] | m2[1];
	// Shadows of software-owned bits
	always_ff @(posedge mclk) begin
		if (reset) begin
			c0 <= 8'h00;
			c2 <= 8'h00;
			m2 <= 8'h00;
		end else if (wr) begin
			if (reg_addr == 12'h410) c0 <= reg_wdata;
			if (reg_addr == 12'h418) c2 <= reg_wdata;
			if (reg_addr == 12'h419) m2 <= reg_wdata;
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) rl <= '{default: 8'h00};
		else if (wr && reg_addr[11:2] == 10'h115) rl[reg_addr[1:0]] <= reg_wdata;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	property p_ctl_read;
		rd && reg_addr == 12'h410 |=> (reg_rdata & 8'h55) == (c0 & 8'h55);
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("run or type bit wrong");
	property p_flag_read;
		rd && reg_addr == 12'h410 |=> reg_rdata[5] == $past(timer0_overflow_flag);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("overflow bit not mirrored");
	property p_reload_read;
		rd && reg_addr[11:2] == 10'h115 |=> reg_rdata == rl[$past(reg_addr[1:0])];
	endproperty
	a_reload_read: assert property (p_reload_read) else $error("reload byte changed");
	property p_unmapped;
		rd && reg_addr == 12'h4ff |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_level_req;
		(!c0[0] && !ext_interrupt0_pin) [*5] |-> ext_ext_interrupt0_pin_request;
	endproperty
	a_level_req: assert property (p_level_req) else $error("low level not requested");
	property p_level_noedge;
		!c0[0] [*2] |-> !ext_ext_interrupt0_pin_edge_flag;
	endproperty
	a_level_noedge: assert property (p_level_noedge) else $error("edge flag in level mode");
	property p_t2_block;
		blk && !wr2 |=> !$rose(timer2_overflow_flag);
	endproperty
	a_t2_block: assert property (p_t2_block) else $error("overflow flag not blocked");
	property p_t2_set;
		timer2_overflow_event && clk_en && !blk && !wr2 |-> ##[1:2] timer2_overflow_flag;
	endproperty
	a_t2_set: assert property (p_t2_set) else $error("overflow flag not set");
	property p_t2_ext_off;
		!c2[3] && !wr2 |=> !$rose(timer2_external_flag);
	endproperty
	a_t2_ext_off: assert property (p_t2_ext_off) else $error("external flag while off");
	c_flag: cover property (rd && reg_addr == 12'h410 ##1 reg_rdata[5]);
	c_req: cover property ($rose(ext_ext_interrupt0_pin_request));
	c_ext: cover property ($rose(timer2_external_flag));
endmodule // dual_timer_modes_properties
bind dual_timer_modes dual_timer_modes_properties chk (.*);
`default_nettype wire

//--- test/timer_pins_model.sv
// Model of the pins around the timers: count, gate/interrupt and external inputs.
// Assumes calls from one bench process at a time; pins idle high.
`timescale 1ns/1ps
`default_nettype none
module timer_pins_model (
	input  wire logic mclk,
	output logic      count0_pin,
	output logic      count1_pin,
	output logic      ext_interrupt0_pin,
	output logic      ext_interrupt1_pin,
	output logic      timer2_external_pin
);
	initial begin
		count0_pin = 1'b1;
		count1_pin = 1'b1;
		ext_interrupt0_pin = 1'b1;
		ext_interrupt1_pin = 1'b1;
		timer2_external_pin = 1'b1;
	end
	// Each level held four cycles, twice the sampling interval
	task pulse(input int k, input int n);
		repeat (n) begin
			@(negedge mclk);
			if (k) count1_pin = 1'b0; else count0_pin = 1'b0;
			repeat (4) @(negedge mclk);
			if (k) count1_pin = 1'b1; else count0_pin = 1'b1;
			repeat (3) @(negedge mclk);
		end
	endtask
	task ext(input int k, input logic v);
		@(negedge mclk);
		case (k)
			0: ext_interrupt0_pin = v;
			1: ext_interrupt1_pin = v;
			default: timer2_external_pin = v;
		endcase
	endtask
endmodule // timer_pins_model
`default_nettype wire

//--- test/dual_timer_modes_tb.sv
// Self-checking bench for dual_timer_modes with a pin model.
// Assumes mclk 100 MHz; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_modes_tb;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        clk_en = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata, v;
	wire logic   count0_pin, count1_pin, timer2_external_pin;
	wire logic   ext_interrupt0_pin, ext_interrupt1_pin;
	logic        timer2_overflow_event = 1'b0;
	logic        timer2_trigger_event = 1'b0;
	logic        ack_timer0 = 1'b0, ack_timer1 = 1'b0, ack_ext0 = 1'b0, ack_ext1 = 1'b0;
	logic        timer0_overflow_flag, timer1_overflow_flag, timer2_overflow_flag;
	logic        ext_ext_interrupt0_pin_edge_flag, ext_int1_edge_flag, timer2_external_flag;
	logic        ext_ext_interrupt0_pin_request, ext_int1_request;
	logic [31:0] seed = 32'h1bf1969c;
	logic [7:0]  blk [5] = '{8'h20, 8'h10, 8'h20, 8'h10, 8'h02};
	int          fails = 0, checks_done = 0, c, n;
	dual_timer_modes uut (.*);
	timer_pins_model pins (.*);
	always #5 mclk = ~mclk;
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	function int per(input int p, input int span, input int r);
		return (4 << 2 * p) * (span - r);
	endfunction
	task finish_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task chkn(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			fails++;
			$display("mismatch at %0t: period %0d want %0d", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask
	task rdc(input logic [11:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk8(reg_rdata, e);
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask
	task wf(input logic sel);
		c = 0;
		while ((sel ? timer1_overflow_flag : timer0_overflow_flag) !== 1'b1 && c < 9000) begin
			@(negedge mclk);
			c++;
		end
		if (c >= 9000) begin
			fails++;
			$display("mismatch at %0t: overflow flag never set", $time);
		end
	endtask
	task setup(input logic [7:0] m, rh, rl, ch, cl, run);
		wr(12'h45c, m);
		wr(12'h455, rh);
		wr(12'h454, rl);
		wr(12'h451, ch);
		wr(12'h450, cl);
		wr(12'h410, run);
	endtask
	initial begin
		#500us;
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		finish_test;
	end
	initial begin
		repeat (12) @(negedge mclk);
		reset = 1'b0;
		rdc(12'h410, 8'h00);
		rdc(12'h418, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rdc(12'h454 + 12'(i), 8'h00);
			v = rnd();
			wr(12'h454 + 12'(i), v);
			rdc(12'h454 + 12'(i), v);
		end
		wr(12'h4ff, v);
		rdc(12'h4ff, 8'h00);
		$display("test registers done");
		for (int p = 0; p < 3; p++) begin
			wr(12'h440, 8'(p));
			setup(8'h00, 8'hff, 8'hfc, 8'hff, 8'hfc, 8'h10);
			wf(0);
			pulse(ack_timer0);
			wf(0);
			chkn(c + 2, per(p, 65536, 16'hfffc));
			wr(12'h410, 8'h00);
		end
		wr(12'h440, 8'h00);
		v = rnd();
		v[7] = 1'b0;
		setup(8'h02, 8'h11, v, 8'h5a, v, 8'h10);
		wf(0);
		pulse(ack_timer0);
		wf(0);
		chkn(c + 2, per(0, 256, int'(v)));
		wr(12'h410, 8'h00);
		rdc(12'h451, 8'h5a);
		setup(8'h01, 8'hff, 8'hfc, 8'hff, 8'hfe, 8'h10);
		wf(0);
		wr(12'h410, 8'h00);
		rdc(12'h451, 8'h00);
		rdc(12'h410, 8'h00);
		$display("test modes 0 1 2 done");
		wr(12'h453, 8'h12);
		wr(12'h452, 8'h34);
		wr(12'h45c, 8'h30);
		wr(12'h410, 8'h40);
		repeat (50) @(negedge mclk);
		rdc(12'h452, 8'h34);
		rdc(12'h410, 8'h40);
		setup(8'h13, 8'h00, 8'h00, 8'hfe, 8'hf0, 8'h40);
		wf(1);
		rdc(12'h450, 8'hf0);
		pulse(ack_timer1);
		rdc(12'h410, 8'h40);
		wr(12'h410, 8'h50);
		wf(0);
		rdc(12'h410, 8'h70);
		wr(12'h410, 8'h00);
		$display("test mode 3 done");
		setup(8'h0d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10);
		v = rnd();
		n = int'(v[3:0]) + 1;
		pins.pulse(0, n);
		repeat (8) @(negedge mclk);
		rdc(12'h450, 8'(n));
		pins.ext(0, 1'b0);
		pins.pulse(0, 3);
		repeat (8) @(negedge mclk);
		rdc(12'h450, 8'(n));
		pins.ext(0, 1'b1);
		wr(12'h410, 8'h00);
		$display("test counter done");
		for (int k = 0; k < 2; k++) begin
			wr(12'h410, 8'(8'h01 << 2 * k));
			pins.ext(k, 1'b0);
			repeat (8) @(negedge mclk);
			rdc(12'h410, 8'(8'h03 << 2 * k));
			chk8({7'h00, k ? ext_int1_edge_flag : ext_ext_interrupt0_pin_edge_flag}, 8'h01);
			pins.ext(k, 1'b1);
			if (k) pulse(ack_ext1); else pulse(ack_ext0);
			rdc(12'h410, 8'(8'h01 << 2 * k));
			wr(12'h410, 8'h00);
			pins.ext(k, 1'b0);
			repeat (8) @(negedge mclk);
			chk8({7'h00, k ? ext_int1_request : ext_ext_interrupt0_pin_request}, 8'h01);
			pins.ext(k, 1'b1);
			repeat (8) @(negedge mclk);
			chk8({7'h00, k ? ext_int1_request : ext_ext_interrupt0_pin_request}, 8'h00);
		end
		$display("test interrupts done");
		pulse(timer2_overflow_event);
		rdc(12'h418, 8'h80);
		wr(12'h418, 8'h00);
		rdc(12'h418, 8'h00);
		wr(12'h450, 8'h3c);
		clk_en = 1'b0;
		wr(12'h450, 8'hc3);
		pulse(timer2_overflow_event);
		clk_en = 1'b1;
		rdc(12'h450, 8'h3c);
		rdc(12'h418, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(i < 2 ? 12'h418 : 12'h419, blk[i]);
			pulse(timer2_overflow_event);
			rdc(12'h418, i < 2 ? blk[i] : 8'h00);
			wr(12'h418, 8'h00);
			wr(12'h419, 8'h00);
		end
		for (int e = 0; e < 2; e++) begin
			wr(12'h418, e ? 8'h08 : 8'h00);
			timer2_trigger_event = 1'b1;
			pins.ext(2, 1'b0);
			repeat (8) @(negedge mclk);
			rdc(12'h418, e ? 8'h48 : 8'h00);
			pins.ext(2, 1'b1);
			timer2_trigger_event = 1'b0;
			wr(12'h418, 8'h00);
		end
		$display("test third timer flags done");
		wr(12'h454, 8'h5a);
		wr(12'h410, 8'h05);
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		rdc(12'h454, 8'h00);
		rdc(12'h410, 8'h00);
		$display("test second reset done");
		finish_test;
	end
endmodule // dual_timer_modes_tb
`default_nettype wire
